/* File: ptm_matrix.sv */
// Trigger matrix routing events, triggers and clocks between peripherals.
`timescale 1ns/100ps
// Behaviour
// - Signals go source to destination in hardware with one fixed cycle of latency.
// - A general timer triggers another general timer, off in Stop.
// - Real-time clock auto-wakeup triggers general_timer_b, off in Stop.
// - Real-time clock events trigger the low_power_timer in every mode.
// - Any internal clock can feed a general timer input channel, off in Stop.
// - Pins route to timers and converter; only low_power_timer path lives in Stop.
module ptm_matrix
	import ptm_pkg::*;
#(
	parameter int N_TIMERS = PTM_N_TIMERS,
	parameter int N_CLOCKS = PTM_N_CLOCKS,
	parameter int N_PINS   = PTM_N_PINS,
	parameter int N_RTC_EV = PTM_N_RTC_EV
) (
	input  wire logic                      clk,            // System clock, 125 MHz.
	input  wire logic                      rst_n,          // Asynchronous reset, active low.
	input  wire ptm_mode_t                 mode,           // Current power mode.
	input  wire logic [N_TIMERS-1:0]       tmr_trgo,       // Trigger outputs of general timers.
	input  wire logic [N_TIMERS-1:0][PTM_SEL_W-1:0] tmr_trg_sel, // Timer trigger source select.
	input  wire logic [N_TIMERS-1:0]       tmr_trg_src_pin,// Take timer trigger from a pin.
	input  wire logic                      rtc_wakeup,     // Real-time clock auto-wakeup event.
	input  wire logic                      tmr_b_wk_en,    // Route auto-wakeup to general_timer_b.
	input  wire logic [N_RTC_EV-1:0]       rtc_events,     // Real-time clock alarm/tamper events.
	input  wire logic [PTM_SEL_W-1:0]      lpt_trg_sel,    // Low-power timer trigger select.
	input  wire logic                      lpt_trg_src_pin,// Low-power timer trigger from a pin.
	input  wire logic [N_CLOCKS-1:0]       int_clocks,     // Internal clock sources, sampled.
	input  wire logic [N_TIMERS-1:0][PTM_SEL_W-1:0] tmr_ch_sel,  // Timer channel source select.
	input  wire logic [N_TIMERS-1:0]       tmr_ch_src_clk, // Take channel from a clock source.
	input  wire logic [N_PINS-1:0]         pins,           // Pin levels.
	input  wire logic [PTM_SEL_W-1:0]      lpt_ch_sel,     // Low-power timer channel pin select.
	input  wire logic [PTM_SEL_W-1:0]      adc_trg_sel,    // Converter trigger pin select.
	output logic [N_TIMERS-1:0]            tmr_trg_q,      // Trigger into each general timer.
	output logic [N_TIMERS-1:0]            tmr_ch_q,       // Input channel of each general timer.
	output logic                           lpt_trg_q,      // Trigger into the low_power_timer.
	output logic                           lpt_ch_q,       // Channel into the low_power_timer.
	output logic                           adc_trg_q       // Conversion trigger to the converter.
);
	import ptm_pkg::*;

	ptm_gate_if gate ();

	ptm_mode_ctrl u_mode (
		.clk   (clk),
		.rst_n (rst_n),
		.mode  (mode),
		.gate  (gate.ctrl)
	);

	// Bit select with an out-of-range index reading as zero, used by every route except the auto-wakeup.
	function automatic logic pick(input logic [31:0] vec, input int unsigned n,
			input logic [PTM_SEL_W-1:0] sel);
		pick = (int'(sel) < n) ? vec[sel] : 1'b0;
	endfunction

	// The Stop gate looks at the raw mode as well as the registered level, so the very
	// cycle that enters Stop already blocks, and no trigger slips out during entry.
	logic run_ok;
	assign run_ok = !gate.stop_q && (mode != PTM_STOP);

	genvar g;
	generate
		for (g = 0; g < N_TIMERS; g++) begin : g_tmr
			logic trg_d;
			logic ch_d;
			always_comb begin
				trg_d = 1'b0;
				if (tmr_trg_src_pin[g]) begin
					trg_d = pick(32'(pins), N_PINS, tmr_trg_sel[g]);
				end else if (tmr_trg_sel[g] != PTM_SEL_W'(g)) begin
					trg_d = pick(32'(tmr_trgo), N_TIMERS, tmr_trg_sel[g]);
				end
				// Timer index 1 is general_timer_b and may also take the auto-wakeup.
				if (g == 1 && tmr_b_wk_en) begin
					trg_d = trg_d | rtc_wakeup;
				end
				if (tmr_ch_src_clk[g]) begin
					ch_d = pick(32'(int_clocks), N_CLOCKS, tmr_ch_sel[g]);
				end else begin
					ch_d = pick(32'(pins), N_PINS, tmr_ch_sel[g]);
				end
			end

			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					tmr_trg_q[g] <= 1'b0;
					tmr_ch_q[g]  <= 1'b0;
				end else begin
					tmr_trg_q[g] <= trg_d & run_ok;
					tmr_ch_q[g]  <= ch_d & run_ok;
				end
			end

			tmr_stop_off_a: assert property (@(posedge clk) disable iff (!rst_n)
				(mode == PTM_STOP) |=> !tmr_trg_q[g] && !tmr_ch_q[g])
				else $error("general timer route active in Stop");
		end
	endgenerate

	logic lpt_trg_d;
	always_comb begin
		if (lpt_trg_src_pin) begin
			lpt_trg_d = pick(32'(pins), N_PINS, lpt_trg_sel);
		end else begin
			lpt_trg_d = pick(32'(rtc_events), N_RTC_EV, lpt_trg_sel);
		end
	end

	// Low-power timer paths ignore the Stop gate; they must keep running there.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lpt_trg_q <= 1'b0;
			lpt_ch_q  <= 1'b0;
		end else begin
			lpt_trg_q <= lpt_trg_d;
			lpt_ch_q  <= pick(32'(pins), N_PINS, lpt_ch_sel);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			adc_trg_q <= 1'b0;
		end else begin
			adc_trg_q <= pick(32'(pins), N_PINS, adc_trg_sel) & run_ok;
		end
	end

	lpt_rtc_route_a: assert property (@(posedge clk) disable iff (!rst_n)
		!lpt_trg_src_pin && lpt_trg_sel == 3'h0 && rtc_events[0] |=> lpt_trg_q)
		else $error("rtc event did not reach low-power timer");

	lpt_pin_route_a: assert property (@(posedge clk) disable iff (!rst_n)
		lpt_trg_src_pin && lpt_trg_sel == 3'h0 |=> lpt_trg_q == $past(pins[0]))
		else $error("pin did not reach low-power timer trigger");

	adc_stop_off_a: assert property (@(posedge clk) disable iff (!rst_n)
		(mode == PTM_STOP) |=> !adc_trg_q)
		else $error("converter trigger active in Stop");

	adc_pin_route_a: assert property (@(posedge clk) disable iff (!rst_n)
		mode != PTM_STOP && !gate.stop_q && adc_trg_sel == 3'h0
		|=> adc_trg_q == $past(pins[0]))
		else $error("converter trigger latency wrong");

	tmr_chain_a: assert property (@(posedge clk) disable iff (!rst_n)
		run_ok && !tmr_trg_src_pin[1] && tmr_trg_sel[1] == 3'h0 && tmr_trgo[0]
		|=> tmr_trg_q[1])
		else $error("timer to timer trigger lost");

	tmr_b_wake_a: assert property (@(posedge clk) disable iff (!rst_n)
		run_ok && tmr_b_wk_en && rtc_wakeup |=> tmr_trg_q[1])
		else $error("auto-wakeup did not reach general_timer_b");

	clk_meas_a: assert property (@(posedge clk) disable iff (!rst_n)
		run_ok && tmr_ch_src_clk[0] && tmr_ch_sel[0] == 3'h1
		|=> tmr_ch_q[0] == $past(int_clocks[1]))
		else $error("clock source not routed to timer channel");

	wake_restore_a: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(mode == PTM_STOP) ##1 (mode != PTM_STOP && tmr_b_wk_en && rtc_wakeup)
		|=> tmr_trg_q[1])
		else $error("route not restored after wakeup");

	// The cycle right after Stop ends is still closed: the registered gate holds it,
	// which costs one cycle of wakeup latency but keeps a stale sample from leaking out.
	stop_exit_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(mode == PTM_STOP)
		|=> tmr_trg_q == '0 && tmr_ch_q == '0 && !adc_trg_q)
		else $error("route opened in the cycle after Stop");

	// Low-power timer routes must keep carrying in Stop, both from events and pins.
	lpt_stop_rtc_a: assert property (@(posedge clk) disable iff (!rst_n)
		mode == PTM_STOP && !lpt_trg_src_pin && lpt_trg_sel == 3'h1
		|=> lpt_trg_q == $past(rtc_events[1]))
		else $error("rtc event blocked in Stop");

	lpt_stop_pin_a: assert property (@(posedge clk) disable iff (!rst_n)
		mode == PTM_STOP && lpt_trg_src_pin && lpt_trg_sel == 3'h4
		|=> lpt_trg_q == $past(pins[4]))
		else $error("pin trigger blocked in Stop");

	lpt_ch_route_a: assert property (@(posedge clk) disable iff (!rst_n)
		lpt_ch_sel == 3'h2
		|=> lpt_ch_q == $past(pins[2]))
		else $error("pin did not reach low-power timer channel");

	// Selects past the end of a source vector read as zero rather than wrapping.
	lpt_rtc_range_a: assert property (@(posedge clk) disable iff (!rst_n)
		!lpt_trg_src_pin && lpt_trg_sel == 3'h7
		|=> !lpt_trg_q)
		else $error("out of range rtc select not zero");

	clk_range_a: assert property (@(posedge clk) disable iff (!rst_n)
		tmr_ch_src_clk[2] && tmr_ch_sel[2] == 3'h6
		|=> !tmr_ch_q[2])
		else $error("out of range clock select not zero");

	// A timer never triggers itself; timer 0 has no auto-wakeup path either.
	tmr_self_sel_a: assert property (@(posedge clk) disable iff (!rst_n)
		!tmr_trg_src_pin[0] && tmr_trg_sel[0] == 3'h0
		|=> !tmr_trg_q[0])
		else $error("timer triggered by itself");

	tmr_pin_trg_a: assert property (@(posedge clk) disable iff (!rst_n)
		run_ok && tmr_trg_src_pin[2] && tmr_trg_sel[2] == 3'h5
		|=> tmr_trg_q[2] == $past(pins[5]))
		else $error("pin did not reach timer trigger");

	tmr_ch_pin_a: assert property (@(posedge clk) disable iff (!rst_n)
		run_ok && !tmr_ch_src_clk[1] && tmr_ch_sel[1] == 3'h7
		|=> tmr_ch_q[1] == $past(pins[7]))
		else $error("pin did not reach timer channel");

	// The always-on level must be up once reset has been gone for a full cycle.
	gate_live_a: assert property (@(posedge clk) disable iff (!rst_n)
		$past(rst_n)
		|-> gate.live_q)
		else $error("always-on gate level not raised");

endmodule

/* File: ptm_pkg.sv */
// Package with power modes, route counts and timing constants for the trigger matrix.
package ptm_pkg;

	// Power modes seen by the matrix.
	typedef enum logic [2:0] {
		PTM_RUN,
		PTM_SLEEP,
		PTM_LP_RUN,
		PTM_LP_SLEEP,
		PTM_STOP
	} ptm_mode_t;

	localparam int PTM_N_TIMERS   = 3;
	localparam int PTM_N_CLOCKS   = 4;
	localparam int PTM_N_PINS     = 8;
	localparam int PTM_N_RTC_EV   = 3;
	localparam int PTM_SEL_W      = 3;

	// Route latency through the matrix in clock cycles, fixed for every path.
	localparam int PTM_LATENCY    = 1;

	// Reset values of the route selects.
	localparam logic [PTM_SEL_W-1:0] PTM_SEL_RST = 3'h0;

endpackage

/* File: ptm_gate_if.sv */
// Interface carrying the per-mode route gating decision inside the trigger matrix.
`timescale 1ns/100ps
interface ptm_gate_if;
	logic stop_q;  // Routes not allowed in Stop are held off.
	logic live_q;  // Routes allowed in Stop are open.

	modport ctrl (output stop_q, output live_q);
	modport user (input stop_q, input live_q);
endinterface

/* File: ptm_mode_ctrl.sv */
// Power mode tracker that produces the route gating levels.
`timescale 1ns/100ps
module ptm_mode_ctrl
	import ptm_pkg::*;
(
	input  wire logic      clk,    // System clock.
	input  wire logic      rst_n,  // Asynchronous reset, active low.
	input  wire ptm_mode_t mode,   // Current power mode.
	ptm_gate_if.ctrl       gate    // Gating levels to the matrix.
);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gate.stop_q <= 1'b0;
			gate.live_q <= 1'b0;
		end else begin
			gate.stop_q <= (mode == PTM_STOP);
			gate.live_q <= 1'b1;
		end
	end
endmodule

/* File: ptm_periph_model.sv */
// Behavioural model of the peripherals that feed the trigger matrix.
`timescale 1ns/100ps
module ptm_periph_model
	import ptm_pkg::*;
(
	input  wire logic              clk,        // System clock.
	input  wire logic [31:0]       rnd,        // Random word.
	output logic      [2:0]        tmr_trgo,   // Timer triggers.
	output logic                   rtc_wakeup, // Auto-wakeup.
	output logic      [2:0]        rtc_events, // Clock events.
	output logic      [3:0]        int_clocks, // Internal clocks.
	output logic      [7:0]        pins        // Pin levels.
);
	initial {tmr_trgo, rtc_wakeup, rtc_events, int_clocks, pins} = '0;
	// Sources move just after an edge, like peripherals clocked by clk.
	always @(posedge clk) begin
		{tmr_trgo, rtc_wakeup, rtc_events, int_clocks, pins} <= rnd[18:0];
	end
endmodule

/* File: testbench.sv */
// Self-checking bench for the trigger matrix.
`timescale 1ns/100ps
module testbench;
	import ptm_pkg::*;
	logic clk, rst_n, stop_seen, rtc_wakeup, tmr_b_wk_en, lpt_trg_src_pin;
	logic lpt_trg_q, lpt_ch_q, adc_trg_q;
	logic [31:0] lfsr_q, rnd;
	ptm_mode_t mode;
	logic [2:0] tmr_trgo, tmr_trg_src_pin, tmr_ch_src_clk, tmr_trg_q, tmr_ch_q, rtc_events;
	logic [2:0][2:0] tmr_trg_sel, tmr_ch_sel;
	logic [2:0] lpt_trg_sel, lpt_ch_sel, adc_trg_sel;
	logic [3:0] int_clocks;
	logic [7:0] pins;
	logic [8:0] exp_v;
	logic [8:0] exp_q[$];
	int n_mismatch, n_checks;

	ptm_periph_model periph (.clk, .rnd, .tmr_trgo, .rtc_wakeup, .rtc_events, .int_clocks, .pins);
	ptm_matrix uut (.clk, .rst_n, .mode, .tmr_trgo, .tmr_trg_sel, .tmr_trg_src_pin, .rtc_wakeup,
		.tmr_b_wk_en, .rtc_events, .lpt_trg_sel, .lpt_trg_src_pin, .int_clocks, .tmr_ch_sel,
		.tmr_ch_src_clk, .pins, .lpt_ch_sel, .adc_trg_sel, .tmr_trg_q, .tmr_ch_q, .lpt_trg_q,
		.lpt_ch_q, .adc_trg_q);

	function automatic logic [31:0] lfsr_next(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction

	// Gate covers the Stop cycle and the one after it, so wakeup cannot leak a pulse.
	function automatic logic [8:0] expect_out();
		logic [2:0] t, c;
		logic g, l;
		g = (mode == PTM_STOP) || stop_seen;
		for (int i = 0; i < 3; i++) begin
			t[i] = tmr_trg_src_pin[i] ? pins[tmr_trg_sel[i]] :
				(tmr_trg_sel[i] < 3'h3 && tmr_trg_sel[i] != i && tmr_trgo[tmr_trg_sel[i]]);
			c[i] = tmr_ch_src_clk[i] ? (tmr_ch_sel[i] < 3'h4 && int_clocks[tmr_ch_sel[i]]) :
				pins[tmr_ch_sel[i]];
		end
		t[1] = t[1] | (rtc_wakeup & tmr_b_wk_en);
		l = lpt_trg_src_pin ? pins[lpt_trg_sel] : (lpt_trg_sel < 3'h3 && rtc_events[lpt_trg_sel]);
		return {g ? 3'h0 : t, g ? 3'h0 : c, l, pins[lpt_ch_sel], ~g & pins[adc_trg_sel]};
	endfunction

	task automatic check(input logic [2:0] seen, input logic [2:0] want);
		n_checks++;
		if (seen !== want) begin
			n_mismatch++;
			$display("FAIL %0t outputs %b expected %b", $time, seen, want);
		end
	endtask

	task automatic print_verdict();
		if (n_mismatch == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	initial begin
		#40000;
		n_mismatch++;
		print_verdict();
	end

	always @(posedge clk) begin
		#1;
		if (exp_q.size() > 0) begin
			exp_v = exp_q.pop_front();
			check(tmr_trg_q, exp_v[8:6]);
			check(tmr_ch_q, exp_v[5:3]);
			check({lpt_trg_q, lpt_ch_q, adc_trg_q}, exp_v[2:0]);
		end
	end

	initial begin
		rst_n = 1'b0;
		lfsr_q = 32'h2;
		rnd = 32'h2;
		stop_seen = 1'b0;
		mode = PTM_RUN;
		{tmr_trg_sel, tmr_trg_src_pin, tmr_b_wk_en, lpt_trg_sel, lpt_trg_src_pin} = '0;
		{tmr_ch_sel, tmr_ch_src_clk, lpt_ch_sel, adc_trg_sel} = '0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		repeat (3000) begin
			@(posedge clk);
			exp_q.push_back(expect_out());
			stop_seen = (mode == PTM_STOP);
			lfsr_q = lfsr_next(lfsr_q);
			rnd <= lfsr_q;
			lfsr_q = lfsr_next(lfsr_q);
			mode <= ptm_mode_t'(lfsr_q[2:0] % 3'h5);
			{tmr_trg_sel, tmr_trg_src_pin, tmr_b_wk_en, lpt_trg_sel, lpt_trg_src_pin} <= lfsr_q[19:3];
			lfsr_q = lfsr_next(lfsr_q);
			{tmr_ch_sel, tmr_ch_src_clk, lpt_ch_sel, adc_trg_sel} <= lfsr_q[17:0];
		end
		@(posedge clk);
		#2;
		print_verdict();
	end
endmodule
